// *** design/lcd_driver_control_registers.v ***
`timescale 1ns/100ps
`default_nettype none
`include "lcd_regs_consts.vh"
module lcd_driver_control_registers (
    // clock and reset
    input wire clk,
    input wire rst_b,
    // host bus pins, 80-style
    input wire cs_n,
    input wire reg_select,
    input wire wr_n,
    input wire rd_n,
    input wire [7:0] data_in,
    output reg [7:0] data_out,
    output wire data_oe,
    // display ram port
    output reg ram_wr,
    output reg ram_rd,
    output reg [7:0] ram_wdata,
    input wire [7:0] ram_rdata,
    output reg [5:0] column_addr_q,
    output reg [6:0] row_addr_q,
    // display timing from the scan logic
    input wire frame_tick,
    // control outputs
    output reg ext_supply_ctrl_out,
    output reg amp_enable,
    output reg osc_enable,
    output reg run_enable,
    output reg drivers_active,
    output reg drivers_alternate,
    output reg invert_display,
    output reg seg_reverse,
    output reg [1:0] bias_sel,
    output reg word_6bit,
    output reg grey_fixed,
    output reg [1:0] duty_sel,
    output reg partial_mode,
    output reg inc_column,
    output reg blink_active
);
    // -------------------------------------------
    // registers
    // -------------------------------------------
    reg [4:0] register_index_q;
    reg [7:0] general_control_one_q;
    reg [7:0] general_control_two_q;
    reg wr_prev_q;
    reg rd_prev_q;
    wire [3:0] bus_s;
    wire cs_s;
    wire rs_s;
    wire wr_s;
    wire rd_s;
    wire wr_go;
    wire rd_go;
    wire [5:0] col_max;
    wire blink_phase;
    // -------------------------------------------
    // pin synchronisation
    // -------------------------------------------
    // bus is async to clk; strobes pass three stages
    // access at any time outside reset
    bus_sync #(
        .W(4)
    ) u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .async_in({cs_n, reg_select, wr_n, rd_n}),
        .sync_out(bus_s)
    );
    assign cs_s = bus_s[3];
    assign rs_s = bus_s[2];
    assign wr_s = bus_s[1];
    assign rd_s = bus_s[0];
    // data must stay stable past the synchronised strobe, sampled at its rising edge
    // no strobe edges under reset
    assign wr_go = rst_b && !cs_s && wr_s && !wr_prev_q;
    assign rd_go = rst_b && !cs_s && rd_s && !rd_prev_q;
    assign data_oe = rst_b && !cs_n && !rd_n && reg_select;
    assign col_max = general_control_two_q[`C2_WLS] ?
        `COL_MAX_6BIT : `COL_MAX_8BIT;
    // -------------------------------------------
    // register writes and ram access
    // -------------------------------------------
    always @(posedge clk) begin
        if (!rst_b) begin
            wr_prev_q <= 1'b1;
            rd_prev_q <= 1'b1;
            register_index_q <= 5'h00;
            general_control_one_q <= `REG_RESET;
            general_control_two_q <= `REG_RESET;
            column_addr_q <= 6'h00;
            row_addr_q <= 7'h00;
            data_out <= `REG_RESET;
            ram_wr <= 1'b0;
            ram_rd <= 1'b0;
            ram_wdata <= `REG_RESET;
        end else begin
            wr_prev_q <= wr_s;
            rd_prev_q <= rd_s;
            ram_wr <= 1'b0;
            ram_rd <= 1'b0;
            if (wr_go && !rs_s) begin
                register_index_q <= data_in[4:0];
            end else if (wr_go && rs_s) begin
                if (register_index_q == `REG_CTRL_ONE) begin
                    general_control_one_q <= data_in;
                end else if (register_index_q == `REG_CTRL_TWO) begin
                    general_control_two_q <= data_in;
                end else if (register_index_q == `REG_COLUMN) begin
                    // out-of-range ignored
                    // unused top bits carry no weight
                    if (data_in[5:0] <= col_max) begin
                        column_addr_q <= data_in[5:0];
                    end
                end else if (register_index_q == `REG_ROW) begin
                    if (data_in[6:0] <= `ROW_MAX) begin
                        row_addr_q <= data_in[6:0];
                    end
                end else if (register_index_q == `REG_RAM_DATA) begin
                    ram_wr <= 1'b1;
                    ram_wdata <= data_in;
                    if (general_control_two_q[`C2_INC]) begin
                        column_addr_q <= (column_addr_q >= col_max) ?
                            6'h00 : column_addr_q + 6'h01;
                    end else begin
                        row_addr_q <= (row_addr_q >= `ROW_MAX) ?
                            7'h00 : row_addr_q + 7'h01;
                    end
                end
            end
            // latch ram word, shown on next read
            if (rd_go && rs_s && register_index_q == `REG_RAM_DATA) begin
                data_out <= ram_rdata;
                ram_rd <= 1'b1;
                // no read increment in rmw mode
                if (!general_control_one_q[`C1_RMW]) begin
                    if (general_control_two_q[`C2_INC]) begin
                        column_addr_q <= (column_addr_q >= col_max) ?
                            6'h00 : column_addr_q + 6'h01;
                    end else begin
                        row_addr_q <= (row_addr_q >= `ROW_MAX) ?
                            7'h00 : row_addr_q + 7'h01;
                    end
                end
            end
        end
    end
    // -------------------------------------------
    // blink counter
    // -------------------------------------------
    // counter tied to blink bit
    blink_timer u_blink (
        .clk(clk),
        .rst_b(rst_b),
        .blink_enable(general_control_two_q[`C2_BLK]),
        .frame_tick(frame_tick),
        .blink_phase_q(blink_phase)
    );
    // -------------------------------------------
    // decoded control outputs
    // -------------------------------------------
    // registered so the analog side never sees decode glitches
    always @(posedge clk) begin
        if (!rst_b) begin
            ext_supply_ctrl_out <= 1'b0;
            amp_enable <= 1'b0;
            osc_enable <= 1'b1;
            run_enable <= 1'b1;
            drivers_active <= 1'b0;
            drivers_alternate <= 1'b0;
            invert_display <= 1'b0;
            seg_reverse <= 1'b0;
            bias_sel <= 2'b00;
            word_6bit <= 1'b0;
            grey_fixed <= 1'b0;
            duty_sel <= 2'b00;
            partial_mode <= 1'b0;
            inc_column <= 1'b0;
            blink_active <= 1'b0;
        end else begin
            ext_supply_ctrl_out <= general_control_one_q[`C1_PWR];
            amp_enable <= general_control_one_q[`C1_AMP];
            osc_enable <= !general_control_one_q[`C1_STANDBY_MODE];
            run_enable <= !general_control_one_q[`C1_HALT] &&
                !general_control_one_q[`C1_STANDBY_MODE];
            drivers_active <= general_control_one_q[`C1_DISPLAY_ON] &&
                !general_control_one_q[`C1_STANDBY_MODE];
            drivers_alternate <= general_control_one_q[`C1_DISPLAY_ON] &&
                !general_control_one_q[`C1_STANDBY_MODE];
            invert_display <= general_control_one_q[`C1_REV];
            seg_reverse <= general_control_one_q[`C1_SEGDIR];
            bias_sel <= {general_control_two_q[`C2_BIAS_HI],
                general_control_two_q[`C2_BIAS_LO]};
            word_6bit <= general_control_two_q[`C2_WLS];
            grey_fixed <= general_control_two_q[`C2_GRAY];
            duty_sel <= {general_control_two_q[`C2_DUTY_HI],
                general_control_two_q[`C2_DUTY_LO]};
            partial_mode <= general_control_two_q[`C2_DUTY_HI] &&
                general_control_two_q[`C2_DUTY_LO];
            inc_column <= general_control_two_q[`C2_INC];
            blink_active <= general_control_two_q[`C2_BLK] && blink_phase;
        end
    end
endmodule
`default_nettype wire

// *** design/lcd_regs_consts.vh ***
`ifndef LCD_REGS_CONSTS_VH
`define LCD_REGS_CONSTS_VH
// register numbers held in the index register
`define REG_CTRL_ONE 5'h00
`define REG_CTRL_TWO 5'h01
`define REG_COLUMN 5'h02
`define REG_ROW 5'h03
`define REG_RAM_DATA 5'h04
`define REG_LAST 5'h10
// reset value of every register
`define REG_RESET 8'h00
// control one field positions
`define C1_RMW 7
`define C1_DISPLAY_ON 6
`define C1_STANDBY_MODE 5
`define C1_PWR 4
`define C1_AMP 3
`define C1_REV 2
`define C1_HALT 1
`define C1_SEGDIR 0
// control two field positions
`define C2_BIAS_HI 7
`define C2_BIAS_LO 6
`define C2_WLS 5
`define C2_GRAY 4
`define C2_DUTY_HI 3
`define C2_DUTY_LO 2
`define C2_INC 1
`define C2_BLK 0
// address limits
`define COL_MAX_8BIT 6'h27
`define COL_MAX_6BIT 6'h35
`define ROW_MAX 7'h40
// blink toggles on the frame after the count reaches this, once per 64 frames
`define BLINK_FRAMES 6'h3f
`endif

// *** design/bus_sync.v ***
`timescale 1ns/100ps
`default_nettype none
// three-stage synchroniser; change accepted when stages two and three agree
module bus_sync #(
    parameter W = 1
) (
    // clock and reset
    input wire clk,
    input wire rst_b,
    // async in, clean out
    input wire [W-1:0] async_in,
    output reg [W-1:0] sync_out
);
    reg [W-1:0] s1_q;
    reg [W-1:0] s2_q;
    reg [W-1:0] s3_q;
    genvar i;
    // -------------------------------
    // per-bit chain
    // -------------------------------
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            always @(posedge clk) begin
                if (!rst_b) begin
                    s1_q[i] <= 1'b1;
                    s2_q[i] <= 1'b1;
                    s3_q[i] <= 1'b1;
                    sync_out[i] <= 1'b1;
                end else begin
                    s1_q[i] <= async_in[i];
                    s2_q[i] <= s1_q[i];
                    s3_q[i] <= s2_q[i];
                    // only follow when the last two stages agree
                    if (s2_q[i] == s3_q[i]) begin
                        sync_out[i] <= s3_q[i];
                    end
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// *** design/blink_timer.v ***
`timescale 1ns/100ps
`default_nettype none
`include "lcd_regs_consts.vh"
// blink phase counter driven by frame pulses
module blink_timer (
    // clock and reset
    input wire clk,
    input wire rst_b,
    // control
    input wire blink_enable,
    input wire frame_tick,
    // phase out
    output reg blink_phase_q
);
    reg [5:0] frame_cnt_q;
    // ---------------------------------------
    // counter
    // ---------------------------------------
    always @(posedge clk) begin
        if (!rst_b) begin
            frame_cnt_q <= 6'h00;
            blink_phase_q <= 1'b0;
        end else if (!blink_enable) begin
            frame_cnt_q <= 6'h00;
            blink_phase_q <= 1'b0;
        end else if (frame_tick) begin
            if (frame_cnt_q == `BLINK_FRAMES) begin
                frame_cnt_q <= 6'h00;
                blink_phase_q <= ~blink_phase_q;
            end else begin
                frame_cnt_q <= frame_cnt_q + 6'h01;
            end
        end
    end
endmodule
`default_nettype wire

// *** bench/lcd_regs_checker.sv ***
`timescale 1ns/100ps
`default_nettype none
module lcd_regs_checker (
    // clock and reset
    input wire clk,
    input wire rst_b,
    // bus and ram strobes
    input wire cs_n,
    input wire reg_select,
    input wire rd_n,
    input wire data_oe,
    input wire ram_wr,
    input wire ram_rd,
    // state and decoded controls
    input wire [5:0] column_addr_q,
    input wire [6:0] row_addr_q,
    input wire osc_enable,
    input wire run_enable,
    input wire drivers_active,
    input wire drivers_alternate,
    input wire [1:0] duty_sel,
    input wire partial_mode
);
// ------------------------------------
// port relations
// ------------------------------------
    // two reset edges so decoded outputs have caught up
    a_reset_clear: assert property (@(posedge clk) !rst_b [*2] |=>
        osc_enable && run_enable && column_addr_q == 6'h00
        && row_addr_q == 7'h00) else $error("reset did not clear state");
    a_drivers_off: assert property (@(posedge clk) !rst_b [*2] |=>
        !drivers_active && !drivers_alternate)
        else $error("drivers not off in reset");
    a_reset_quiet: assert property (@(posedge clk) !rst_b [*2] |=>
        !data_oe && !ram_wr && !ram_rd) else $error("bus active in reset");
    a_standby_halts: assert property (@(posedge clk)
        disable iff (!rst_b) !osc_enable |-> !run_enable && !drivers_active)
        else $error("standby left logic running");
    a_partial_duty: assert property (@(posedge clk)
        disable iff (!rst_b) partial_mode == (duty_sel == 2'b11))
        else $error("partial mode not tied to duty code");
    a_column_limit: assert property (@(posedge clk)
        disable iff (!rst_b) column_addr_q <= 6'h35)
        else $error("column address above limit");
    a_row_limit: assert property (@(posedge clk)
        disable iff (!rst_b) row_addr_q <= 7'h40)
        else $error("row address above limit");
    a_read_enable: assert property (@(posedge clk)
        disable iff (!rst_b) data_oe == (!cs_n && !rd_n && reg_select))
        else $error("read drive enable wrong");
    a_write_pulse: assert property (@(posedge clk)
        disable iff (!rst_b) ram_wr |=> !ram_wr [*3])
        else $error("ram write not a single pulse");
    a_read_pulse: assert property (@(posedge clk)
        disable iff (!rst_b) ram_rd |=> !ram_rd [*3])
        else $error("ram read not a single pulse");
endmodule
`default_nettype wire

// *** bench/host_bus_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module host_bus_model (
    // clock
    input wire clk,
    // host bus pins
    output logic cs_n,
    output logic reg_select,
    output logic wr_n,
    output logic rd_n,
    output logic [7:0] data_in,
    input wire [7:0] data_out
);
// ------------------------------------
// bus cycles
// ------------------------------------
    // idle bus at time zero
    initial begin
        cs_n = 1'b1;
        reg_select = 1'b0;
        wr_n = 1'b1;
        rd_n = 1'b1;
        data_in = 8'h5a;
    end
    // strobe low then high, each five clocks
    task automatic xfer(input logic rs, input logic we,
                        input logic [7:0] d, output logic [7:0] q);
        @(posedge clk);
        cs_n <= 1'b0;
        reg_select <= rs;
        data_in <= d;
        wr_n <= !we;
        rd_n <= we;
        repeat (5) @(posedge clk);
        q = data_out;
        wr_n <= 1'b1;
        rd_n <= 1'b1;
        // data held past the synchroniser, then scrambled
        repeat (5) @(posedge clk);
        cs_n <= 1'b1;
        data_in <= ~d;
        repeat (4) @(posedge clk);
    endtask
    // index first with unused bits zero, then data
    task automatic wreg(input logic [4:0] r, input logic [7:0] d);
        logic [7:0] q;
        xfer(1'b0, 1'b1, {3'b000, r}, q);
        xfer(1'b1, 1'b1, d, q);
    endtask
endmodule
`default_nettype wire

// *** bench/lcd_driver_control_registers_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module lcd_driver_control_registers_tb_top;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic frame_tick = 1'b0;
    logic [7:0] ram_rdata = 8'h00;
    logic [7:0] wdat = 8'h00;
    logic [7:0] q;
    logic [6:0] e1;
    logic [7:0] e2;
    logic [7:0] v1 [6] = '{8'h40, 8'h50, 8'h6c, 8'h4a, 8'h47, 8'h00};
    logic [7:0] v2 [6] = '{8'h44, 8'h88, 8'hcc, 8'h31, 8'h1e, 8'h00};
    int errors = 0;
    int n_tests = 0;
    wire cs_n, reg_select, wr_n, rd_n, data_oe, ram_wr, ram_rd;
    wire [7:0] data_in, data_out, ram_wdata;
    wire [5:0] column_addr_q;
    wire [6:0] row_addr_q;
    wire ext_supply_ctrl_out, amp_enable, osc_enable, run_enable;
    wire drivers_active, drivers_alternate, invert_display, seg_reverse;
    wire word_6bit, grey_fixed, partial_mode, inc_column, blink_active;
    wire [1:0] bias_sel, duty_sel;
    wire [6:0] c1_o = {ext_supply_ctrl_out, amp_enable, osc_enable,
        run_enable, drivers_active, invert_display, seg_reverse};
    wire [7:0] c2_o = {bias_sel, word_6bit, grey_fixed, duty_sel,
        partial_mode, inc_column};
    wire [20:0] ram_view = {wdat, column_addr_q, row_addr_q};
// ------------------------------------
// design, host and ram stand-in
// ------------------------------------
    lcd_driver_control_registers lcd_driver_control_registers_inst (
        .clk, .rst_b, .cs_n, .reg_select, .wr_n, .rd_n, .data_in,
        .data_out, .data_oe, .ram_wr, .ram_rd, .ram_wdata, .ram_rdata,
        .column_addr_q, .row_addr_q, .frame_tick, .ext_supply_ctrl_out,
        .amp_enable, .osc_enable, .run_enable, .drivers_active,
        .drivers_alternate, .invert_display, .seg_reverse, .bias_sel,
        .word_6bit, .grey_fixed, .duty_sel, .partial_mode, .inc_column,
        .blink_active);
    host_bus_model host_bus_model_inst (.clk, .cs_n, .reg_select, .wr_n,
        .rd_n, .data_in, .data_out);
    always #20 clk = ~clk;
    // ram answers with a tag of the column so reads are traceable
    always @(posedge clk) begin
        ram_rdata <= {2'b10, column_addr_q};
        if (ram_wr)
            wdat <= ram_wdata;
    end
    function automatic logic [6:0] c1_exp(input logic [7:0] v);
        return {v[4], v[3], !v[5], !(v[5] | v[1]), v[6] & !v[5],
            v[2], v[0]};
    endfunction
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge clk);
            frame_tick <= 1'b1;
            @(posedge clk);
            frame_tick <= 1'b0;
        end
        repeat (4) @(posedge clk);
    endtask
    task automatic results;
        $display("tests %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // watchdog, well past the expected 1400 or so cycles
    initial begin
        #2000000;
        errors++;
        results();
    end
// ------------------------------------
// test sequence
// ------------------------------------
    initial begin
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        `CHK("ctl1 reset", c1_exp(8'h00), c1_o)
        `CHK("ctl2 reset", 8'h00, c2_o)
        `CHK("alternate", 1'b0, drivers_alternate)
        `CHK("addr reset", 13'h0000, ram_view[12:0])
        foreach (v1[k]) begin
            host_bus_model_inst.wreg(5'h00, v1[k]);
            e1 = c1_exp(v1[k]);
            `CHK("ctl1", e1, c1_o)
        end
        foreach (v2[k]) begin
            host_bus_model_inst.wreg(5'h01, v2[k]);
            e2 = {v2[k][7:2], &v2[k][3:2], v2[k][1]};
            `CHK("ctl2", e2, c2_o)
        end
        host_bus_model_inst.wreg(5'h05, 8'hff);
        host_bus_model_inst.wreg(5'h1f, 8'hff);
        `CHK("unused regs", 15'h1800, {c1_o, c2_o})
        host_bus_model_inst.wreg(5'h02, 8'h27);
        host_bus_model_inst.wreg(5'h02, 8'h28);
        `CHK("col 8 bit", 6'h27, column_addr_q)
        host_bus_model_inst.wreg(5'h01, 8'h20);
        host_bus_model_inst.wreg(5'h02, 8'h35);
        host_bus_model_inst.wreg(5'h02, 8'h36);
        `CHK("col 6 bit", 6'h35, column_addr_q)
        host_bus_model_inst.wreg(5'h03, 8'h40);
        host_bus_model_inst.wreg(5'h03, 8'h41);
        `CHK("row max", 7'h40, row_addr_q)
        host_bus_model_inst.wreg(5'h02, 8'h05);
        host_bus_model_inst.wreg(5'h03, 8'h10);
        host_bus_model_inst.wreg(5'h01, 8'h02);
        host_bus_model_inst.wreg(5'h04, 8'ha5);
        `CHK("ram wr x", 21'h14a310, ram_view)
        host_bus_model_inst.wreg(5'h01, 8'h00);
        host_bus_model_inst.wreg(5'h04, 8'h3c);
        `CHK("ram wr y", 21'h078311, ram_view)
        host_bus_model_inst.xfer(1'b1, 1'b0, 8'h00, q);
        host_bus_model_inst.xfer(1'b1, 1'b0, 8'h00, q);
        `CHK("read incr", 15'h4313, {q, row_addr_q})
        host_bus_model_inst.wreg(5'h00, 8'h80);
        host_bus_model_inst.wreg(5'h02, 8'h09);
        // point the index back at ram data, keeping rmw set
        host_bus_model_inst.xfer(1'b0, 1'b1, 8'h04, q);
        host_bus_model_inst.xfer(1'b1, 1'b0, 8'h00, q);
        `CHK("stale latch", 8'h86, q)
        host_bus_model_inst.xfer(1'b1, 1'b0, 8'h00, q);
        `CHK("rmw read", 15'h4493, {q, row_addr_q})
        host_bus_model_inst.wreg(5'h04, 8'h11);
        `CHK("rmw write", 7'h14, row_addr_q)
        host_bus_model_inst.wreg(5'h01, 8'h01);
        ticks(63);
        `CHK("blink early", 1'b0, blink_active)
        ticks(1);
        `CHK("blink on", 1'b1, blink_active)
        host_bus_model_inst.wreg(5'h01, 8'h00);
        host_bus_model_inst.wreg(5'h01, 8'h01);
        ticks(63);
        `CHK("blink restart", 1'b0, blink_active)
        rst_b <= 1'b0;
        host_bus_model_inst.wreg(5'h00, 8'h58);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        `CHK("reset again", 20'h30000, {c1_o, ram_view[12:0]})
        results();
    end
endmodule
bind lcd_driver_control_registers lcd_regs_checker lcd_regs_checker_inst (
    .clk, .rst_b, .cs_n, .reg_select, .rd_n, .data_oe, .ram_wr, .ram_rd,
    .column_addr_q, .row_addr_q, .osc_enable, .run_enable, .drivers_active,
    .drivers_alternate, .duty_sel, .partial_mode);
`default_nettype wire
